// >>> include/sfp_pkg.sv
package sfp_pkg;

  // ----------------------------------------------------------------
  // opcodes and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SEQ_A = 8'hAD;
  localparam logic [7:0] OP_SEQ_B = 8'hAF;
  localparam logic [7:0] OP_DUAL = 8'hA2;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_STATUS = 8'h25;

  localparam int ADDR_W = 24;
  localparam int BYTE_W = 8;
  localparam int WORD_W = ADDR_W + BYTE_W;
  localparam logic [23:0] ARRAY_LAST = 24'h01FFFF;
  localparam logic [23:0] ADDR_ONE = 24'h000001;
  localparam int BLK_LSB = 16;
  localparam int BLK_W = 5;
  localparam int NUM_BLK = 32;
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_IDX_W = 8;
  localparam logic [7:0] PAGE_LAST = 8'hFF;
  localparam logic [7:0] ERASED = 8'hFF;

  // bit counts within a frame
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] HDR_BITS = 6'h20;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam logic [2:0] SEQ_LAST_BIT = 3'h7;
  localparam logic [2:0] DUAL_LAST_PAIR = 3'h6;
  localparam logic [2:0] DUAL_STEP = 3'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int BYTE_PROG_TIME_NS = 20000;
  localparam int PAGE_PROG_TIME_NS = 1000000;
  localparam int BYTE_PROG_CYC = (BYTE_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_PROG_CYC = (PAGE_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 24;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    FR_IDLE = 7'h01,
    FR_CMD = 7'h02,
    FR_ADDR = 7'h04,
    FR_SEQ_DATA = 7'h08,
    FR_DUAL_DATA = 7'h10,
    FR_STATUS = 7'h20,
    FR_SKIP = 7'h40
  } sfp_frame_type;

  typedef enum logic [2:0] {
    EN_IDLE = 3'h1,
    EN_PUSH = 3'h2,
    EN_WAIT = 3'h4
  } sfp_eng_type;

endpackage : sfp_pkg

// >>> src/sfp_pin_sync.sv
module sfp_pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] stab_q;
  logic [W-1:0] prev_q;

  // ----------------------------------------------------------------
  // two-stage synchroniser plus edge history
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      stab_q <= RST_VAL;
      prev_q <= RST_VAL;
    end
    else
    begin
      meta_q <= async_in;
      stab_q <= meta_q;
      prev_q <= stab_q;
    end
  end

  // edges seen only on the settled stage
  assign sync_out = stab_q;
  assign rise = stab_q & ~prev_q;
  assign fall = ~stab_q & prev_q;

endmodule : sfp_pin_sync

// >>> src/sfp_prog_top.sv
module sfp_prog_top #(
  parameter int BYTE_CYC = sfp_pkg::BYTE_PROG_CYC,
  parameter int PAGE_CYC = sfp_pkg::PAGE_PROG_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_in,
  output logic so_out,
  output logic so_oe,
  input wire logic [sfp_pkg::NUM_BLK-1:0] blk_protect,
  input wire logic erase_suspended,
  input wire logic [sfp_pkg::BLK_W-1:0] susp_block,
  input wire logic err_clear,
  output logic arr_wr_valid,
  output logic [sfp_pkg::ADDR_W-1:0] arr_wr_addr,
  output logic [sfp_pkg::BYTE_W-1:0] arr_wr_data,
  input wire logic arr_wr_ready,
  input wire logic arr_prog_fail,
  input wire logic arr_erase_fail,
  output logic write_enable_latch,
  output logic ready_busy_flag,
  output logic erase_error_flag,
  output logic program_error_flag,
  output logic seq_mode
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_s, pin_rise, pin_fall;
  logic cs_fall, cs_rise, sck_rise, si_s, so_s;

  sfp_pin_sync #(.W(4), .RST_VAL(4'h8)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({cs_n, sck, si, so_in}),
    .sync_out(pin_s),
    .rise(pin_rise),
    .fall(pin_fall)
  );
  assign cs_fall = pin_fall[3];
  assign cs_rise = pin_rise[3];
  assign sck_rise = pin_rise[2] & ~pin_s[3];
  assign si_s = pin_s[1];
  assign so_s = pin_s[0];

  // ----------------------------------------------------------------
  // frame decoder
  // ----------------------------------------------------------------
  sfp_pkg::sfp_frame_type fr_q, fr_d;
  logic [5:0] cnt_q, cnt_d;
  logic [7:0] op_q, op_d, sh_q, sh_d, seq_byte_q, seq_byte_d, ptr_q, ptr_d;
  logic [23:0] addr_q, addr_d;
  logic [2:0] dbit_q, dbit_d;
  logic got_q, got_d, so_oe_q, so_oe_d, so_out_q, so_out_d;
  logic [7:0] page_q [sfp_pkg::PAGE_BYTES];
  logic [7:0] page_d [sfp_pkg::PAGE_BYTES];
  logic [sfp_pkg::PAGE_BYTES-1:0] mask_q, mask_d;
  logic wel_set_req, wel_clr_req, abort_req, prot_req, launch_req;
  logic wel_q, busy_q, seq_q;

  always_comb
  begin
    fr_d = fr_q;
    cnt_d = cnt_q;
    op_d = op_q;
    sh_d = sh_q;
    addr_d = addr_q;
    dbit_d = dbit_q;
    got_d = got_q;
    seq_byte_d = seq_byte_q;
    ptr_d = ptr_q;
    page_d = page_q;
    mask_d = mask_q;
    wel_set_req = 1'b0;
    wel_clr_req = 1'b0;
    abort_req = 1'b0;
    prot_req = 1'b0;
    launch_req = 1'b0;
    if (cs_fall)
    begin
      fr_d = sfp_pkg::FR_CMD;
      cnt_d = '0;
      dbit_d = '0;
      got_d = 1'b0;
    end
    else if (cs_rise && fr_q != sfp_pkg::FR_IDLE)
    begin
      fr_d = sfp_pkg::FR_IDLE;
      unique case (fr_q)
        sfp_pkg::FR_CMD:
        begin
          wel_set_req = (cnt_q == sfp_pkg::CMD_BITS) && (op_q == sfp_pkg::OP_WREN) && !busy_q;
          wel_clr_req = (cnt_q == sfp_pkg::CMD_BITS) && (op_q == sfp_pkg::OP_WRDI);
        end
        sfp_pkg::FR_ADDR: abort_req = 1'b1;
        sfp_pkg::FR_SEQ_DATA, sfp_pkg::FR_DUAL_DATA:
        begin
          if (!got_q || dbit_q != 3'h0)
            abort_req = 1'b1;
          else if ((op_q == sfp_pkg::OP_DUAL || !seq_q)
                   && blk_protect[addr_q[sfp_pkg::BLK_LSB +: sfp_pkg::BLK_W]])
            prot_req = 1'b1;
          else
            launch_req = wel_q;
        end
        sfp_pkg::FR_STATUS, sfp_pkg::FR_SKIP: ;
      endcase
    end
    else if (sck_rise)
    begin
      unique case (fr_q)
        sfp_pkg::FR_CMD:
        begin
          if (cnt_q != sfp_pkg::CNT_MAX)
            cnt_d = cnt_q + 6'h01;
          if (cnt_q < sfp_pkg::CMD_BITS)
            op_d = {op_q[6:0], si_s};
          if (cnt_q == sfp_pkg::CMD_BITS - 6'h01)
          begin
            if (op_d == sfp_pkg::OP_STATUS)
              fr_d = sfp_pkg::FR_STATUS;
            else if (busy_q)
              fr_d = sfp_pkg::FR_SKIP;
            else if (op_d == sfp_pkg::OP_SEQ_A || op_d == sfp_pkg::OP_SEQ_B)
              fr_d = seq_q ? sfp_pkg::FR_SEQ_DATA : sfp_pkg::FR_ADDR;
            else if (op_d == sfp_pkg::OP_DUAL && !seq_q)
              fr_d = sfp_pkg::FR_ADDR;
            else if (op_d != sfp_pkg::OP_WREN && op_d != sfp_pkg::OP_WRDI)
              fr_d = sfp_pkg::FR_SKIP;
          end
        end
        sfp_pkg::FR_ADDR:
        begin
          addr_d = {addr_q[22:0], si_s};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == sfp_pkg::HDR_BITS - 6'h01)
          begin
            fr_d = (op_q == sfp_pkg::OP_DUAL) ? sfp_pkg::FR_DUAL_DATA : sfp_pkg::FR_SEQ_DATA;
            ptr_d = addr_d[sfp_pkg::PAGE_IDX_W-1:0];
            mask_d = '0;
          end
        end
        sfp_pkg::FR_SEQ_DATA:
        begin
          sh_d = {sh_q[6:0], si_s};
          dbit_d = dbit_q + 3'h1;
          if (dbit_q == sfp_pkg::SEQ_LAST_BIT)
          begin
            seq_byte_d = sh_d;
            got_d = 1'b1;
          end
        end
        sfp_pkg::FR_DUAL_DATA:
        begin
          sh_d = {sh_q[5:0], so_s, si_s};
          dbit_d = dbit_q + sfp_pkg::DUAL_STEP;
          if (dbit_q == sfp_pkg::DUAL_LAST_PAIR)
          begin
            page_d[ptr_q] = sh_d;
            mask_d[ptr_q] = 1'b1;
            ptr_d = ptr_q + 8'h01;
            got_d = 1'b1;
          end
        end
        sfp_pkg::FR_IDLE, sfp_pkg::FR_STATUS, sfp_pkg::FR_SKIP: ;
      endcase
    end
    so_oe_d = (fr_d == sfp_pkg::FR_STATUS);
    so_out_d = busy_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      fr_q <= sfp_pkg::FR_IDLE;
      cnt_q <= '0;
      op_q <= '0;
      sh_q <= '0;
      addr_q <= '0;
      dbit_q <= '0;
      got_q <= 1'b0;
      seq_byte_q <= sfp_pkg::ERASED;
      ptr_q <= '0;
      page_q <= '{default: sfp_pkg::ERASED};
      mask_q <= '0;
      so_oe_q <= 1'b0;
      so_out_q <= 1'b0;
    end
    else
    begin
      fr_q <= fr_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      dbit_q <= dbit_d;
      got_q <= got_d;
      seq_byte_q <= seq_byte_d;
      ptr_q <= ptr_d;
      page_q <= page_d;
      mask_q <= mask_d;
      so_oe_q <= so_oe_d;
      so_out_q <= so_out_d;
    end
  end

  // ----------------------------------------------------------------
  // program engine, write enable and sequential state
  // ----------------------------------------------------------------
  sfp_pkg::sfp_eng_type en_q, en_d;
  logic wel_d, busy_d, seq_d, dual_q, dual_d, fail_q, fail_d, ee_q, ee_d, pe_q, pe_d;
  logic [23:0] seq_addr_q, seq_addr_d, next_addr;
  logic [15:0] base_q, base_d;
  logic [7:0] idx_q, idx_d;
  logic [sfp_pkg::TMR_W-1:0] tmr_q, tmr_d;
  logic buf_in_valid, buf_in_ready;
  logic [sfp_pkg::WORD_W-1:0] buf_in_data;

  always_comb
  begin
    en_d = en_q;
    busy_d = busy_q;
    seq_d = seq_q;
    dual_d = dual_q;
    fail_d = fail_q | arr_prog_fail;
    seq_addr_d = seq_addr_q;
    base_d = base_q;
    idx_d = idx_q;
    tmr_d = tmr_q;
    buf_in_valid = 1'b0;
    buf_in_data = {seq_addr_q, seq_byte_q};
    next_addr = seq_addr_q + sfp_pkg::ADDR_ONE;
    wel_d = wel_q;
    if (wel_set_req)
      wel_d = 1'b1;
    if (wel_clr_req || abort_req || prot_req)
      wel_d = 1'b0;
    pe_d = (pe_q & ~err_clear) | arr_prog_fail;
    ee_d = (ee_q & ~err_clear) | arr_erase_fail;
    unique case (en_q)
      sfp_pkg::EN_IDLE:
        if (launch_req)
        begin
          busy_d = 1'b1;
          fail_d = 1'b0;
          dual_d = (op_q == sfp_pkg::OP_DUAL);
          base_d = addr_q[23:8];
          idx_d = '0;
          if (op_q != sfp_pkg::OP_DUAL && !seq_q)
          begin
            seq_addr_d = addr_q;
            seq_d = 1'b1;
          end
          en_d = sfp_pkg::EN_PUSH;
        end
      sfp_pkg::EN_PUSH:
        if (dual_q)
        begin
          buf_in_valid = mask_q[idx_q];
          buf_in_data = {base_q, idx_q, page_q[idx_q]};
          if (!mask_q[idx_q] || buf_in_ready)
          begin
            idx_d = idx_q + 8'h01;
            if (idx_q == sfp_pkg::PAGE_LAST)
            begin
              tmr_d = sfp_pkg::TMR_W'(PAGE_CYC);
              en_d = sfp_pkg::EN_WAIT;
            end
          end
        end
        else
        begin
          buf_in_valid = 1'b1;
          if (buf_in_ready)
          begin
            tmr_d = sfp_pkg::TMR_W'(BYTE_CYC);
            en_d = sfp_pkg::EN_WAIT;
          end
        end
      sfp_pkg::EN_WAIT:
      begin
        if (tmr_q != '0)
          tmr_d = tmr_q - sfp_pkg::TMR_W'(1);
        else if (!arr_wr_valid)
        begin
          busy_d = 1'b0;
          en_d = sfp_pkg::EN_IDLE;
          if (dual_q)
            wel_d = 1'b0;
          else if (!fail_d)
          begin
            seq_addr_d = next_addr;
            if (seq_addr_q == sfp_pkg::ARRAY_LAST)
            begin
              seq_d = 1'b0;
              wel_d = 1'b0;
            end
            else if (blk_protect[next_addr[sfp_pkg::BLK_LSB +: sfp_pkg::BLK_W]])
            begin
              seq_d = 1'b0;
              wel_d = 1'b0;
            end
            else if (erase_suspended
                     && next_addr[sfp_pkg::BLK_LSB +: sfp_pkg::BLK_W] == susp_block)
              seq_d = 1'b0;
          end
        end
      end
    endcase
    seq_d = seq_d & wel_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      en_q <= sfp_pkg::EN_IDLE;
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      seq_q <= 1'b0;
      dual_q <= 1'b0;
      fail_q <= 1'b0;
      ee_q <= 1'b0;
      pe_q <= 1'b0;
      seq_addr_q <= '0;
      base_q <= '0;
      idx_q <= '0;
      tmr_q <= '0;
    end
    else
    begin
      en_q <= en_d;
      wel_q <= wel_d;
      busy_q <= busy_d;
      seq_q <= seq_d;
      dual_q <= dual_d;
      fail_q <= fail_d;
      ee_q <= ee_d;
      pe_q <= pe_d;
      seq_addr_q <= seq_addr_d;
      base_q <= base_d;
      idx_q <= idx_d;
      tmr_q <= tmr_d;
    end
  end

  // write words towards the array through the two-entry buffer
  sfp_skid_buf #(.W(sfp_pkg::WORD_W)) u_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(buf_in_valid),
    .in_data(buf_in_data),
    .in_ready(buf_in_ready),
    .out_valid(arr_wr_valid),
    .out_data({arr_wr_addr, arr_wr_data}),
    .out_ready(arr_wr_ready)
  );

  assign so_out = so_out_q;
  assign so_oe = so_oe_q;
  assign write_enable_latch = wel_q;
  assign ready_busy_flag = busy_q;
  assign erase_error_flag = ee_q;
  assign program_error_flag = pe_q;
  assign seq_mode = seq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_abort_clears_wel: assert property (abort_req |=> !wel_q && en_q == sfp_pkg::EN_IDLE)
    else $error("abort left write enable set or started programming");
  a_protect_no_prog: assert property (prot_req |=> !wel_q && !busy_q)
    else $error("protected start address was programmed");
  a_seq_last_byte: assert property ((fr_q == sfp_pkg::FR_SEQ_DATA && sck_rise && !cs_rise
    && !cs_fall && dbit_q == sfp_pkg::SEQ_LAST_BIT) |=> seq_byte_q == $past(sh_d))
    else $error("sequential byte latch missed the last byte");
  a_wel_ends_seq: assert property (!wel_q |-> !seq_q)
    else $error("sequential mode kept without write enable");
  a_top_no_wrap: assert property ((en_q == sfp_pkg::EN_WAIT && tmr_q == '0 && !arr_wr_valid
    && !dual_q && !fail_d && seq_addr_q == sfp_pkg::ARRAY_LAST) |=> !seq_q && !wel_q)
    else $error("sequential run wrapped past the last array byte");
  a_seq_advance: assert property ((en_q == sfp_pkg::EN_WAIT && tmr_q == '0 && !arr_wr_valid
    && !dual_q && !fail_d) |=> seq_addr_q == $past(seq_addr_q) + sfp_pkg::ADDR_ONE)
    else $error("sequential address did not step by one");
  a_page_wrap: assert property ((fr_q == sfp_pkg::FR_DUAL_DATA && sck_rise && !cs_rise
    && !cs_fall && dbit_q == sfp_pkg::DUAL_LAST_PAIR && ptr_q == sfp_pkg::PAGE_LAST)
    |=> ptr_q == 8'h00 && mask_q[sfp_pkg::PAGE_LAST])
    else $error("page pointer did not wrap within the page");
  a_dual_so_input: assert property (fr_q == sfp_pkg::FR_DUAL_DATA |-> ##1 !so_oe_q)
    else $error("output pin driven during dual data");
  a_status_drive: assert property ((fr_q == sfp_pkg::FR_STATUS && !cs_rise && !cs_fall)
    |=> so_oe_q && so_out_q == $past(busy_q))
    else $error("status frame not driving busy onto the pin");
  a_error_sticky: assert property (arr_prog_fail |=> program_error_flag ##1 (program_error_flag
    || $past(err_clear)))
    else $error("program error flag lost");
  a_launch_busy: assert property (launch_req && en_q == sfp_pkg::EN_IDLE |=> busy_q [*2])
    else $error("programming did not start at chip select rise");

  c_dual_prog: cover property (launch_req && op_q == sfp_pkg::OP_DUAL);
  c_seq_prog: cover property (launch_req && op_q != sfp_pkg::OP_DUAL);
  c_status: cover property (so_oe_q && $fell(so_out_q));
  c_abort: cover property (abort_req);

endmodule : sfp_prog_top

// >>> src/sfp_skid_buf.sv
module sfp_skid_buf #(
  parameter int W = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  logic out_valid_q, out_valid_d;
  logic [W-1:0] out_data_q, out_data_d;
  logic skid_valid_q, skid_valid_d;
  logic [W-1:0] skid_data_q, skid_data_d;
  logic in_ready_q, in_ready_d;
  logic take;

  // ----------------------------------------------------------------
  // two entries: output register and skid register
  // ----------------------------------------------------------------
  always_comb
  begin
    take = in_valid & in_ready_q;
    out_valid_d = out_valid_q;
    out_data_d = out_data_q;
    skid_valid_d = skid_valid_q;
    skid_data_d = skid_data_q;
    if (!out_valid_q || out_ready)
    begin
      if (skid_valid_q)
      begin
        out_valid_d = 1'b1;
        out_data_d = skid_data_q;
        skid_valid_d = take;
        if (take)
          skid_data_d = in_data;
      end
      else
      begin
        out_valid_d = take;
        out_data_d = in_data;
      end
    end
    else if (take)
    begin
      skid_valid_d = 1'b1;
      skid_data_d = in_data;
    end
    in_ready_d = !skid_valid_d; // full when skid holds a word
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
      skid_valid_q <= 1'b0;
      skid_data_q <= '0;
      in_ready_q <= 1'b1;
    end
    else
    begin
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
      skid_valid_q <= skid_valid_d;
      skid_data_q <= skid_data_d;
      in_ready_q <= in_ready_d;
    end
  end

  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

endmodule : sfp_skid_buf

// >>> tb/sfp_host.sv
module sfp_host (
  input wire logic sys_clk,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic so_in,
  input wire logic so_out,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic val = 1'b0;
  // pin level: device drive, host drive or a toggling float
  assign so_in = so_oe ? so_out : val;
  // float toggles on the rising edge, clear of the host's own drive edge
  always @(posedge sys_clk) if (!drv) val <= ~val;
  // link idles deselected with the clock low
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // one link clock, four system clocks each half
  task tick(input logic hi, input logic lo);
    si = lo;
    if (drv) val = hi;
    sck = 1'b0;
    repeat (4) @(negedge sys_clk);
    sck = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : tick
  task open;
    cs_n = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask : open
  // n bits from the top of v, msb first on si
  task ser(input logic [31:0] v, input int n);
    for (int i = 31; i > 31 - n; i--) tick(1'b0, v[i]);
  endtask : ser
  // dual data: odd bits on the output pin
  task dbl(input logic [7:0] b, input int n);
    drv = 1'b1;
    for (int i = 7; i > 7 - n; i -= 2) tick(b[i], b[i-1]);
  endtask : dbl
  // clock back low, deselect, release the data lines
  task close;
    sck = 1'b0;
    repeat (4) @(negedge sys_clk);
    cs_n = 1'b1;
    drv = 1'b0;
    si = ~si;
    repeat (4) @(negedge sys_clk);
  endtask : close
endmodule : sfp_host

// >>> tb/test_serial_flash_program_cmds.sv
module test_serial_flash_program_cmds;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] op;
    logic ad;
    logic [23:0] a;
    logic [15:0] d;
    int nb;
    logic [31:0] pr;
    logic [5:0] su;
    int nw;
    logic [1:0] fl;
  } sfp_row_type;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, sck, si, so_in, so_out, so_oe, arr_wr_valid;
  logic [31:0] blk_protect = '0;
  logic [4:0] susp_block = '0;
  logic arr_wr_ready = 1'b0, arr_prog_fail = 1'b0, arr_erase_fail = 1'b0;
  logic err_clear = 1'b0, erase_suspended = 1'b0;
  logic [23:0] arr_wr_addr;
  logic [7:0] arr_wr_data;
  logic write_enable_latch, ready_busy_flag, erase_error_flag, program_error_flag, seq_mode;
  logic [31:0] wq[$];
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  // opcode, addr sent, addr, data, bits, protect, suspend, words, {wel, seq}
  sfp_row_type rows[11] = '{
    '{sfp_pkg::OP_DUAL, 1'h1, 24'h000010, 16'h5A00, 8, '0, '0, 1, 2'h0},
    '{sfp_pkg::OP_SEQ_A, 1'h1, 24'h01FFFE, 16'hC300, 8, '0, '0, 1, 2'h3},
    '{sfp_pkg::OP_SEQ_B, 1'h0, 24'h01FFFF, 16'h7700, 8, '0, '0, 1, 2'h0},
    '{sfp_pkg::OP_SEQ_B, 1'h1, 24'h030000, 16'h1100, 8, 32'h8, '0, 0, 2'h0},
    '{sfp_pkg::OP_DUAL, 1'h1, 24'h040000, 16'h2200, 8, 32'h10, '0, 0, 2'h0},
    '{sfp_pkg::OP_DUAL, 1'h1, 24'h000050, 16'h3300, 4, '0, '0, 0, 2'h0},
    '{sfp_pkg::OP_SEQ_A, 1'h1, 24'h000060, 16'h4400, 4, '0, '0, 0, 2'h0},
    '{sfp_pkg::OP_SEQ_A, 1'h1, 24'h00FFFF, 16'h5500, 8, 32'h2, '0, 1, 2'h0},
    '{sfp_pkg::OP_SEQ_B, 1'h1, 24'h02FFFF, 16'h6600, 8, '0, 6'h23, 1, 2'h2},
    '{sfp_pkg::OP_SEQ_A, 1'h1, 24'h000070, 16'hAA88, 16, '0, '0, 1, 2'h3},
    '{sfp_pkg::OP_WRDI, 1'h0, 24'h0, 16'h0, 0, '0, '0, 0, 2'h0}
  };
  sfp_prog_top #(.BYTE_CYC(4), .PAGE_CYC(20)) sfp_prog_top_inst (
    .sys_clk, .rst_n, .cs_n, .sck, .si, .so_in, .so_out, .so_oe, .blk_protect,
    .erase_suspended, .susp_block, .err_clear, .arr_wr_valid, .arr_wr_addr,
    .arr_wr_data, .arr_wr_ready, .arr_prog_fail, .arr_erase_fail, .write_enable_latch,
    .ready_busy_flag, .erase_error_flag, .program_error_flag, .seq_mode
  );
  sfp_host sfp_host_inst (.sys_clk, .cs_n, .sck, .si, .so_in, .so_out, .so_oe);
  always #20 sys_clk = ~sys_clk;
  // array side stalls every other cycle
  always @(negedge sys_clk) arr_wr_ready <= ~arr_wr_ready;
  // capture array words, cut a hang short
  always @(posedge sys_clk)
  begin
    if (arr_wr_valid === 1'b1 && arr_wr_ready) wq.push_back({arr_wr_addr, arr_wr_data});
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      end_sim();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // wait for the busy flag to drop, bounded
  task settle;
    repeat (8) @(negedge sys_clk);
    for (int k = 0; k < 3000 && ready_busy_flag !== 1'b0; k++) @(negedge sys_clk);
    chk("ready", '0, ready_busy_flag);
    repeat (4) @(negedge sys_clk);
  endtask : settle
  task cmd(input logic [7:0] op);
    sfp_host_inst.open();
    sfp_host_inst.ser({op, 24'h0}, 8);
    sfp_host_inst.close();
  endtask : cmd
  task run(input sfp_row_type x);
    logic [15:0] dx;
    blk_protect = x.pr;
    erase_suspended = x.su[5];
    susp_block = x.su[4:0];
    cmd(sfp_pkg::OP_WREN);
    wq.delete();
    sfp_host_inst.open();
    sfp_host_inst.ser({x.op, x.a}, x.ad ? 32 : 8);
    if (x.op == sfp_pkg::OP_DUAL) sfp_host_inst.dbl(x.d[15:8], x.nb);
    else if (x.nb > 0) sfp_host_inst.ser({x.d, 16'h0}, x.nb);
    sfp_host_inst.close();
    settle();
    dx = x.d << (x.nb - 8);
    chk("words", x.nw, wq.size());
    if (x.nw > 0) chk("word", {x.a, dx[15:8]}, wq[0]);
    chk("wel seq", x.fl, {write_enable_latch, seq_mode});
  endtask : run
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // reset, table rows, then wrap, status pin and page overflow
  initial
  begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("reset", '0, {write_enable_latch, ready_busy_flag, program_error_flag, so_oe});
    $display("reset test done");
    foreach (rows[i])
    begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    cmd(sfp_pkg::OP_WREN);
    wq.delete();
    sfp_host_inst.open();
    sfp_host_inst.ser({sfp_pkg::OP_DUAL, 24'h0000FE}, 32);
    for (int i = 0; i < 3; i++) sfp_host_inst.dbl(8'hAA + 8'h11 * i[7:0], 8);
    sfp_host_inst.close();
    repeat (4) @(negedge sys_clk);
    sfp_host_inst.open();
    sfp_host_inst.ser({sfp_pkg::OP_STATUS, 24'h0}, 8);
    repeat (4) @(negedge sys_clk);
    chk("pin busy", 32'h3, {so_oe, so_out});
    arr_prog_fail = 1'b1;
    arr_erase_fail = 1'b1;
    @(negedge sys_clk);
    arr_prog_fail = 1'b0;
    arr_erase_fail = 1'b0;
    settle();
    chk("pin ready", 32'h2, {so_oe, so_out});
    chk("err flags", 32'h3, {erase_error_flag, program_error_flag});
    sfp_host_inst.close();
    chk("wrap", 32'h000000CC, wq[0]);
    chk("wrap", 32'h0000FEAA, wq[1]);
    chk("wrap", 32'h0000FFBB, wq[2]);
    $display("wrap test done");
    // fail pulse and clear together: set wins, then clear alone
    err_clear = 1'b1;
    arr_prog_fail = 1'b1;
    @(negedge sys_clk);
    arr_prog_fail = 1'b0;
    chk("err set wins", 32'h1, {erase_error_flag, program_error_flag});
    @(negedge sys_clk);
    err_clear = 1'b0;
    chk("err clear", 32'h0, {erase_error_flag, program_error_flag});
    $display("error clear test done");
    cmd(sfp_pkg::OP_WREN);
    wq.delete();
    sfp_host_inst.open();
    sfp_host_inst.ser({sfp_pkg::OP_DUAL, 24'h000100}, 32);
    for (int i = 0; i < 257; i++) sfp_host_inst.dbl(i == 0 ? 8'h11 : 8'h22, 8);
    sfp_host_inst.close();
    settle();
    chk("page", 32'h00010022, wq[0]);
    chk("page", 32'h100, wq.size());
    $display("page test done");
    // dual program without write enable: nothing reaches the array
    wq.delete();
    sfp_host_inst.open();
    sfp_host_inst.ser({sfp_pkg::OP_DUAL, 24'h000200}, 32);
    sfp_host_inst.dbl(8'h5A, 8);
    sfp_host_inst.close();
    settle();
    chk("no enable", 32'h0, wq.size());
    $display("enable test done");
    end_sim();
  end
endmodule : test_serial_flash_program_cmds
